// *** hdl/fpse_pkg.sv ***
// shared constants and types for the front panel settings editor
package fpse_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned IDLE_TIMEOUT_S = 30;
    localparam longint unsigned IDLE_TIMEOUT_CYC_L = longint'(IDLE_TIMEOUT_S) * longint'(CLK_HZ);
    localparam logic [31:0] IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_CYC_L[31:0];

    // switch pulse positions inside the carrier vector
    localparam int SW_SEL = 0;
    localparam int SW_LEFT = 1;
    localparam int SW_RIGHT = 2;
    localparam int SW_UP = 3;
    localparam int SW_DOWN = 4;
    localparam int SW_COUNT = 5;

    // cursor positions: 0..3 top digits, 4 exit marker, 5..8 bottom digits
    localparam logic [3:0] POS_FIRST = 4'h0;
    localparam logic [3:0] POS_EXIT = 4'h4;
    localparam logic [3:0] POS_BOT0 = 4'h5;
    localparam logic [3:0] POS_LAST = 4'h8;

    // gain held in half-dB units
    localparam logic [5:0] GAIN_MIN = 6'h00;
    localparam logic [5:0] GAIN_MAX = 6'h28;
    localparam logic [5:0] GAIN_STEP = 6'h01;

    localparam logic [3:0] BCD_NINE = 4'h9;

    typedef enum logic [2:0] {
        MN_NORMAL,
        MN_UP_FREQ,
        MN_DN_FREQ,
        MN_UP_GAIN,
        MN_DN_GAIN,
        MN_SAVE
    } fpse_menu_t;

    // frequencies are four BCD digits of MHz, most significant digit first
    typedef struct packed {
        logic [15:0] up_in;
        logic [15:0] up_out;
        logic [15:0] dn_in;
        logic [15:0] dn_out;
        logic [5:0] up_gain;
        logic [5:0] dn_gain;
    } fpse_set_t;

    localparam int SET_W = $bits(fpse_set_t);
    localparam fpse_set_t SET_RESET = '0;
endpackage

// *** hdl/fpse_sw_if.sv ***
// carrier from the switch synchroniser to the editor core
`timescale 1ns/1ps
interface fpse_sw_if #(
    parameter int NLOCK = 2
);
    logic [fpse_pkg::SW_COUNT-1:0] press;
    logic [NLOCK-1:0] lock_ok;

    modport src (output press, output lock_ok);
    modport dst (input press, input lock_ok);
endinterface

// *** hdl/fpse_sw_sync.sv ***
// pin synchroniser and press edge detector
`timescale 1ns/1ps
module fpse_sw_sync #(
    parameter int NLOCK = 2
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [fpse_pkg::SW_COUNT-1:0] sw_raw,
    input wire logic [NLOCK-1:0] lock_raw,
    fpse_sw_if.src sw
);
    localparam int W = fpse_pkg::SW_COUNT + NLOCK;

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [fpse_pkg::SW_COUNT-1:0] prev_q;
    logic [fpse_pkg::SW_COUNT-1:0] sw_lvl;

    assign sw_lvl = sync_q[fpse_pkg::SW_COUNT-1:0];
    // one pulse per press; holding a switch does not auto-repeat
    assign sw.press = sw_lvl & ~prev_q;
    assign sw.lock_ok = sync_q[W-1:fpse_pkg::SW_COUNT];

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            // loops read locked until sampled, so no false alarm after reset
            meta_q <= {{NLOCK{1'b1}}, {fpse_pkg::SW_COUNT{1'b0}}};
            sync_q <= {{NLOCK{1'b1}}, {fpse_pkg::SW_COUNT{1'b0}}};
            prev_q <= '0;
        end else if (ce) begin
            meta_q <= {lock_raw, sw_raw};
            sync_q <= meta_q;
            prev_q <= sw_lvl;
        end
    end
endmodule

// *** hdl/fpse_editor.sv ***
// front panel settings editor core: menus, cursor, pending edits, save and alarm
`timescale 1ns/1ps
// How it works
// - thirty idle seconds while editing discard pending edits, back to normal
// - each select press while editing steps to the next menu, unless the cursor is on the exit marker
// - vertical rocker changes the digit under the cursor at once
// - horizontal rocker moves cursor; top start wraps down to bottom end, bottom end wraps up to top start
// - edited frequencies reach the synthesizers only after a yes save
// - select on the exit marker jumps to the save prompt
// - yes stores all pending settings; no restores previous values
// - the save-prompt press returns to the main display
// - gain edits apply immediately, are stored only on yes
// - one vertical step changes gain by half a dB
// - alarm whenever any oscillator loop reports loss of lock
// - gains are limited to zero through 20.0 dB
// - committed settings live in non-volatile storage, restored at power-up
module fpse_editor #(
    parameter int NLOCK = 2,
    parameter logic [31:0] TIMEOUT_CYC = fpse_pkg::IDLE_TIMEOUT_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic sw_sel,
    input wire logic sw_left,
    input wire logic sw_right,
    input wire logic sw_up,
    input wire logic sw_down,
    input wire logic [NLOCK-1:0] pll_lock,
    input wire logic [fpse_pkg::SET_W-1:0] nv_rd_data,
    output logic nv_wr_en,
    output logic [fpse_pkg::SET_W-1:0] nv_wr_data,
    output logic [15:0] syn_up_in,
    output logic [15:0] syn_up_out,
    output logic [15:0] syn_dn_in,
    output logic [15:0] syn_dn_out,
    output logic [5:0] up_gain,
    output logic [5:0] dn_gain,
    output logic [fpse_pkg::SET_W-1:0] shown_set,
    output logic [2:0] menu_code,
    output logic [3:0] cursor,
    output logic save_yes,
    output logic alarm
);
    fpse_sw_if #(.NLOCK(NLOCK)) sw ();

    fpse_sw_sync #(.NLOCK(NLOCK)) u_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .ce(ce),
        .sw_raw({sw_down, sw_up, sw_right, sw_left, sw_sel}),
        .lock_raw(pll_lock),
        .sw(sw)
    );

    function automatic logic [3:0] bcd_step(input logic [3:0] d, input logic up);
        if (up) begin
            bcd_step = (d >= fpse_pkg::BCD_NINE) ? 4'h0 : d + 4'h1;
        end else begin
            bcd_step = (d == 4'h0) ? fpse_pkg::BCD_NINE : d - 4'h1;
        end
    endfunction

    // digit index 0 is the leftmost digit on the display
    function automatic logic [15:0] freq_step(input logic [15:0] f, input logic [1:0] idx, input logic up);
        logic [15:0] r;
        r = f;
        case (idx)
            2'h0: r[15:12] = bcd_step(f[15:12], up);
            2'h1: r[11:8] = bcd_step(f[11:8], up);
            2'h2: r[7:4] = bcd_step(f[7:4], up);
            default: r[3:0] = bcd_step(f[3:0], up);
        endcase
        return r;
    endfunction

    function automatic logic [5:0] gain_step(input logic [5:0] g, input logic up);
        if (up) begin
            gain_step = (g >= fpse_pkg::GAIN_MAX) ? fpse_pkg::GAIN_MAX : g + fpse_pkg::GAIN_STEP;
        end else begin
            gain_step = (g == fpse_pkg::GAIN_MIN) ? fpse_pkg::GAIN_MIN : g - fpse_pkg::GAIN_STEP;
        end
    endfunction

    // a stored image may hold an out-of-range gain; pull it into range on load
    function automatic logic [5:0] gain_fit(input logic [5:0] g);
        gain_fit = (g > fpse_pkg::GAIN_MAX) ? fpse_pkg::GAIN_MAX : g;
    endfunction

    fpse_pkg::fpse_menu_t menu_q, menu_d;
    fpse_pkg::fpse_set_t wk_q, wk_d;
    fpse_pkg::fpse_set_t cm_q, cm_d;
    logic [3:0] cur_q, cur_d;
    logic yes_q, yes_d;
    logic [31:0] tmr_q, tmr_d;
    logic load_q;
    logic nv_wr_q;
    logic alarm_q;

    wire p_sel = sw.press[fpse_pkg::SW_SEL];
    wire p_left = sw.press[fpse_pkg::SW_LEFT];
    wire p_right = sw.press[fpse_pkg::SW_RIGHT];
    wire p_up = sw.press[fpse_pkg::SW_UP];
    wire p_down = sw.press[fpse_pkg::SW_DOWN];
    wire any_press = |sw.press;
    wire horiz = p_left ^ p_right;
    wire vert = p_up ^ p_down;

    wire active = (menu_q != fpse_pkg::MN_NORMAL);
    wire editing = (menu_q == fpse_pkg::MN_UP_FREQ) || (menu_q == fpse_pkg::MN_DN_FREQ) ||
                   (menu_q == fpse_pkg::MN_UP_GAIN) || (menu_q == fpse_pkg::MN_DN_GAIN);
    wire on_exit = (cur_q == fpse_pkg::POS_EXIT);
    wire on_top = (cur_q < fpse_pkg::POS_EXIT);
    wire [1:0] dig_idx = on_top ? cur_q[1:0] : 2'(cur_q - fpse_pkg::POS_BOT0);

    wire tmo_hit = active && !any_press && (tmr_q >= TIMEOUT_CYC - 32'h1);
    wire do_sel = !tmo_hit && p_sel;
    wire do_horiz = !tmo_hit && !p_sel && horiz;
    wire do_vert = !tmo_hit && !p_sel && !horiz && vert && editing && !on_exit;
    wire save_take = do_sel && (menu_q == fpse_pkg::MN_SAVE);

    // restart on action, held at zero on the main display, counts in the save prompt too
    assign tmr_d = (!active || any_press) ? 32'h0 : tmr_q + 32'h1;

    // linear order 0..8 makes the top/bottom wrap fall out naturally
    wire [3:0] cur_right = (cur_q >= fpse_pkg::POS_LAST) ? fpse_pkg::POS_FIRST : cur_q + 4'h1;
    wire [3:0] cur_left = (cur_q == fpse_pkg::POS_FIRST) ? fpse_pkg::POS_LAST : cur_q - 4'h1;

    always_comb begin
        menu_d = menu_q;
        cur_d = cur_q;
        yes_d = yes_q;
        if (tmo_hit) begin
            menu_d = fpse_pkg::MN_NORMAL;
        end else if (do_sel) begin
            cur_d = fpse_pkg::POS_FIRST;
            if (editing && on_exit) begin
                menu_d = fpse_pkg::MN_SAVE;
                yes_d = 1'b1;
            end else begin
                unique case (menu_q)
                    fpse_pkg::MN_NORMAL: menu_d = fpse_pkg::MN_UP_FREQ;
                    fpse_pkg::MN_UP_FREQ: menu_d = fpse_pkg::MN_DN_FREQ;
                    fpse_pkg::MN_DN_FREQ: menu_d = fpse_pkg::MN_UP_GAIN;
                    fpse_pkg::MN_UP_GAIN: menu_d = fpse_pkg::MN_DN_GAIN;
                    fpse_pkg::MN_DN_GAIN: begin
                        menu_d = fpse_pkg::MN_SAVE;
                        yes_d = 1'b1;
                    end
                    // the save press ends at the main display
                    fpse_pkg::MN_SAVE: menu_d = fpse_pkg::MN_NORMAL;
                    default: menu_d = fpse_pkg::MN_NORMAL;
                endcase
            end
        end else if (do_horiz) begin
            if (menu_q == fpse_pkg::MN_SAVE) begin
                yes_d = !yes_q;
            end else if (editing) begin
                cur_d = p_right ? cur_right : cur_left;
            end
        end
    end

    always_comb begin
        wk_d = wk_q;
        cm_d = cm_q;
        if (load_q) begin
            wk_d = fpse_pkg::fpse_set_t'(nv_rd_data);
            wk_d.up_gain = gain_fit(wk_d.up_gain);
            wk_d.dn_gain = gain_fit(wk_d.dn_gain);
            cm_d = wk_d;
        end else if (tmo_hit || (save_take && !yes_q)) begin
            wk_d = cm_q;
        end else if (save_take && yes_q) begin
            cm_d = wk_q;
        end else if (do_vert) begin
            unique case (menu_q)
                fpse_pkg::MN_UP_FREQ: begin
                    if (on_top) wk_d.up_in = freq_step(wk_q.up_in, dig_idx, p_up);
                    else wk_d.up_out = freq_step(wk_q.up_out, dig_idx, p_up);
                end
                fpse_pkg::MN_DN_FREQ: begin
                    if (on_top) wk_d.dn_in = freq_step(wk_q.dn_in, dig_idx, p_up);
                    else wk_d.dn_out = freq_step(wk_q.dn_out, dig_idx, p_up);
                end
                fpse_pkg::MN_UP_GAIN: wk_d.up_gain = gain_step(wk_q.up_gain, p_up);
                fpse_pkg::MN_DN_GAIN: wk_d.dn_gain = gain_step(wk_q.dn_gain, p_up);
                default: wk_d = wk_q;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            menu_q <= fpse_pkg::MN_NORMAL;
            cur_q <= fpse_pkg::POS_FIRST;
            yes_q <= 1'b1;
            tmr_q <= 32'h0;
            wk_q <= fpse_pkg::SET_RESET;
            cm_q <= fpse_pkg::SET_RESET;
            load_q <= 1'b1;
            nv_wr_q <= 1'b0;
            alarm_q <= 1'b0;
        end else if (ce) begin
            menu_q <= menu_d;
            cur_q <= cur_d;
            yes_q <= yes_d;
            tmr_q <= tmr_d;
            wk_q <= wk_d;
            cm_q <= cm_d;
            load_q <= 1'b0;
            // write the store on a yes save
            nv_wr_q <= !load_q && save_take && yes_q;
            alarm_q <= !(&sw.lock_ok);
        end
    end

    assign syn_up_in = cm_q.up_in;
    assign syn_up_out = cm_q.up_out;
    assign syn_dn_in = cm_q.dn_in;
    assign syn_dn_out = cm_q.dn_out;
    // gain path follows the pending value
    assign up_gain = wk_q.up_gain;
    assign dn_gain = wk_q.dn_gain;
    assign nv_wr_en = nv_wr_q;
    assign nv_wr_data = cm_q;
    assign shown_set = wk_q;
    assign menu_code = menu_q;
    assign cursor = cur_q;
    assign save_yes = yes_q;
    assign alarm = alarm_q;

    idle_expire_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ce && tmo_hit && !load_q) |=> (menu_q == fpse_pkg::MN_NORMAL) && (wk_q == $past(cm_q)))
        else $error("idle expiry did not discard edits");

    menu_advance_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ce && do_sel && menu_q == fpse_pkg::MN_UP_GAIN && !on_exit) |=> menu_q == fpse_pkg::MN_DN_GAIN)
        else $error("select did not advance the menu");

    digit_change_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ce && !load_q && do_vert && menu_q == fpse_pkg::MN_UP_FREQ && on_top)
        |=> wk_q.up_in != $past(wk_q.up_in))
        else $error("vertical step left the digit unchanged");

    cursor_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ce && do_horiz && editing && p_right && on_exit) |=> cur_q == fpse_pkg::POS_BOT0)
        else $error("cursor did not wrap to the bottom line");

    freq_held_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ce && !load_q && !save_take) |=> $stable(cm_q.up_in) && $stable(cm_q.dn_out))
        else $error("frequency applied without a save");

    exit_jump_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ce && do_sel && editing && on_exit) |=> (menu_q == fpse_pkg::MN_SAVE) && yes_q)
        else $error("exit marker did not open the save prompt");

    save_commit_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ce && !load_q && save_take && yes_q) |=> nv_wr_en && (cm_q == $past(wk_q))
        && (menu_q == fpse_pkg::MN_NORMAL))
        else $error("yes save did not store the pending set");

    gain_step_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ce && !load_q && do_vert && p_up && menu_q == fpse_pkg::MN_DN_GAIN && wk_q.dn_gain < fpse_pkg::GAIN_MAX)
        |=> dn_gain == $past(wk_q.dn_gain) + fpse_pkg::GAIN_STEP)
        else $error("gain step is not half a dB");

    gain_limit_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (up_gain <= fpse_pkg::GAIN_MAX) && (dn_gain <= fpse_pkg::GAIN_MAX))
        else $error("gain above 20.0 dB");

    lock_alarm_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ce && !(&sw.lock_ok)) |=> alarm)
        else $error("lost lock raised no alarm");

    alarm_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ce && (&sw.lock_ok)) |=> !alarm)
        else $error("alarm stayed up with all loops locked");

    menu_return_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ce && save_take) |=> menu_q == fpse_pkg::MN_NORMAL)
        else $error("save press did not return to the main display");

    store_on_yes_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ce && !(save_take && yes_q)) |=> !nv_wr_en)
        else $error("store written without a yes save");

    restore_load_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ce && load_q) |=> syn_up_in == $past(nv_rd_data[fpse_pkg::SET_W-1 -: 16]))
        else $error("stored settings not restored at power-up");

    idle_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ce && (!active || any_press)) |=> tmr_q == 32'h0)
        else $error("idle timer did not restart");
endmodule

// *** sim/fpse_nv_model.sv ***
// behavioural non-volatile store standing behind the editor
`timescale 1ns/1ps
module fpse_nv_model #(
    parameter logic [fpse_pkg::SET_W-1:0] INIT_IMAGE = '0
) (
    input wire logic core_clk,
    input wire logic nv_wr_en,
    input wire logic [fpse_pkg::SET_W-1:0] nv_wr_data,
    output logic [fpse_pkg::SET_W-1:0] nv_rd_data
);
    logic [fpse_pkg::SET_W-1:0] image_q;

    initial begin
        image_q = INIT_IMAGE;
    end

    // survives power loss
    // image only changes on a write pulse, never on reset
    always_ff @(posedge core_clk) begin
        if (nv_wr_en) begin
            image_q <= nv_wr_data;
        end
    end

    assign nv_rd_data = image_q;
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the settings editor
`timescale 1ns/1ps
module testbench;
    localparam logic [75:0] IMG = {16'h1350, 16'h2250, 16'h2350, 16'h1550, 6'h14, 6'h28};
    logic core_clk;
    logic rst_b;
    logic [4:0] sw;
    logic [1:0] pll_lock;
    logic [75:0] nv_rd_data;
    logic nv_wr_en;
    logic [75:0] nv_wr_data;
    logic [15:0] syn_up_in;
    logic [15:0] syn_up_out;
    logic [15:0] syn_dn_in;
    logic [15:0] syn_dn_out;
    logic [5:0] up_gain;
    logic [5:0] dn_gain;
    logic [75:0] shown_set;
    logic [2:0] menu_code;
    logic [3:0] cursor;
    logic save_yes;
    logic alarm;
    fpse_pkg::fpse_set_t shown_s;
    int n_errors;
    int n_compared;
    int n_writes;

    assign shown_s = fpse_pkg::fpse_set_t'(shown_set);

    // short timeout keeps the idle scenario quick
    fpse_editor #(.NLOCK(2), .TIMEOUT_CYC(32'h32)) dut (
        .core_clk(core_clk), .rst_b(rst_b), .ce(1'b1),
        .sw_sel(sw[fpse_pkg::SW_SEL]), .sw_left(sw[fpse_pkg::SW_LEFT]),
        .sw_right(sw[fpse_pkg::SW_RIGHT]), .sw_up(sw[fpse_pkg::SW_UP]),
        .sw_down(sw[fpse_pkg::SW_DOWN]), .pll_lock(pll_lock),
        .nv_rd_data(nv_rd_data), .nv_wr_en(nv_wr_en), .nv_wr_data(nv_wr_data),
        .syn_up_in(syn_up_in), .syn_up_out(syn_up_out), .syn_dn_in(syn_dn_in),
        .syn_dn_out(syn_dn_out), .up_gain(up_gain), .dn_gain(dn_gain),
        .shown_set(shown_set), .menu_code(menu_code), .cursor(cursor),
        .save_yes(save_yes), .alarm(alarm)
    );

    fpse_nv_model #(.INIT_IMAGE(IMG)) nv (
        .core_clk(core_clk), .nv_wr_en(nv_wr_en),
        .nv_wr_data(nv_wr_data), .nv_rd_data(nv_rd_data)
    );

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (nv_wr_en === 1'b1) begin
            n_writes++;
        end
    end

    task automatic chk(input string what, input logic [75:0] exp, input logic [75:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // pin held long enough for the synchroniser, then released before the next press
    task automatic press(input int k);
        @(posedge core_clk);
        #2 sw[k] = 1'b1;
        repeat (4) @(posedge core_clk);
        #2 sw[k] = 1'b0;
        repeat (7) @(posedge core_clk);
        #2;
    endtask

    task automatic do_reset();
        #2 rst_b = 1'b0;
        repeat (8) @(posedge core_clk);
        #2 rst_b = 1'b1;
        repeat (5) @(posedge core_clk);
        #2;
    endtask

    task automatic t_edit_and_save();
        chk("loaded set", IMG, shown_set);
        press(fpse_pkg::SW_SEL);
        chk("menu", 76'h1, 76'(menu_code));
        press(fpse_pkg::SW_RIGHT);
        press(fpse_pkg::SW_UP);
        chk("up_in shown", 76'h1450, 76'(shown_s.up_in));
        chk("syn held", 76'h1350, 76'(syn_up_in));
        press(fpse_pkg::SW_LEFT);
        press(fpse_pkg::SW_LEFT);
        chk("cursor wrap left", 76'h8, 76'(cursor));
        press(fpse_pkg::SW_RIGHT);
        chk("cursor wrap right", 76'h0, 76'(cursor));
        press(fpse_pkg::SW_SEL);
        chk("menu", 76'h2, 76'(menu_code));
        press(fpse_pkg::SW_SEL);
        chk("menu", 76'h3, 76'(menu_code));
        press(fpse_pkg::SW_UP);
        chk("up gain live", 76'h15, 76'(up_gain));
        press(fpse_pkg::SW_SEL);
        press(fpse_pkg::SW_UP);
        chk("dn gain clamp", 76'h28, 76'(dn_gain));
        press(fpse_pkg::SW_SEL);
        chk("menu", 76'h5, 76'(menu_code));
        chk("prompt yes", 76'h1, 76'(save_yes));
        press(fpse_pkg::SW_SEL);
        chk("menu back", 76'h0, 76'(menu_code));
        chk("syn applied", 76'h1450, 76'(syn_up_in));
        chk("syn up_out", 76'h2250, 76'(syn_up_out));
        chk("syn dn_in", 76'h2350, 76'(syn_dn_in));
        chk("syn dn_out", 76'h1550, 76'(syn_dn_out));
        chk("writes", 76'h1, 76'(n_writes));
        chk("stored up_in", 76'h1450, 76'(nv_rd_data[75:60]));
        $display("test edit_and_save finished");
    endtask

    task automatic t_discard_by_no();
        press(fpse_pkg::SW_SEL);
        press(fpse_pkg::SW_UP);
        for (int i = 0; i < 4; i++) begin
            press(fpse_pkg::SW_RIGHT);
        end
        chk("cursor exit", 76'h4, 76'(cursor));
        press(fpse_pkg::SW_SEL);
        chk("jump to prompt", 76'h5, 76'(menu_code));
        press(fpse_pkg::SW_RIGHT);
        chk("prompt no", 76'h0, 76'(save_yes));
        press(fpse_pkg::SW_SEL);
        chk("menu back", 76'h0, 76'(menu_code));
        chk("reverted", 76'h1450, 76'(shown_s.up_in));
        chk("no write", 76'h1, 76'(n_writes));
        $display("test discard_by_no finished");
    endtask

    task automatic t_idle_timeout();
        press(fpse_pkg::SW_SEL);
        press(fpse_pkg::SW_UP);
        repeat (30) @(posedge core_clk);
        // a second step up restarts the idle timer before it expires
        press(fpse_pkg::SW_UP);
        repeat (30) @(posedge core_clk);
        chk("timer restarted", 76'h1, 76'(menu_code));
        repeat (20) @(posedge core_clk);
        chk("timed out", 76'h0, 76'(menu_code));
        chk("edits dropped", 76'h1450, 76'(shown_s.up_in));
        $display("test idle_timeout finished");
    endtask

    task automatic t_alarm_and_power();
        @(posedge core_clk);
        #2 pll_lock = 2'h1;
        repeat (6) @(posedge core_clk);
        #2;
        chk("alarm on", 76'h1, 76'(alarm));
        @(posedge core_clk);
        #2 pll_lock = 2'h3;
        repeat (6) @(posedge core_clk);
        #2;
        chk("alarm off", 76'h0, 76'(alarm));
        @(posedge core_clk);
        do_reset();
        chk("restored up_in", 76'h1450, 76'(shown_s.up_in));
        chk("restored gain", 76'h15, 76'(up_gain));
        $display("test alarm_and_power finished");
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // run needs about 410 cycles; far beyond that means a hang
    initial begin
        #400000;
        n_errors++;
        summarize();
    end

    initial begin
        n_errors = 0;
        n_compared = 0;
        n_writes = 0;
        sw = 5'h00;
        pll_lock = 2'h3;
        rst_b = 1'b0;
        do_reset();
        t_edit_and_save();
        t_discard_by_no();
        t_idle_timeout();
        t_alarm_and_power();
        summarize();
    end
endmodule
